// >>> rtl/pin_mux_pkg.sv
// Operation
// (R1) config bit 0 puts second timer wave A on pin 43
// (R2) config bit 1 puts second timer wave B on pin 42
// (R3) config bit 2 puts first timer wave A on pin 41
// (R4) config bit 3 puts first timer wave B on pin 40
// (R5) config bit 12 drives trace frame on pin 26, trace data on pin 27
// (R6) bits 12 and 9 together choose digital or analog input 1 on pin 27
// (R7) bit 10 chooses digital or analog input 2 on pin 29
// (R8) bits 13 and 11 together choose digital or analog input 3 on pin 30
// (R9) bit 14 chooses digital or reference voltage output on pin 31
// (R10) routing field general setting leaves pins 32 and 33 digital
// (R11) uart routing plus uart mode sends transmit data out pin 32
// (R12) same routing and mode feeds pin 33 as receive data
// (R13) spi master routing, spi mode, master bit: pin 32 out, 33 in
// (R14) two-wire routing and mode: pins 32, 33 are open-drain data, clock
// (R15) first timer capture route b: pin 32 to A, non-half also 33 to B
// (R16) first timer capture route c: pin 43 to A, non-half also 42 to B
// (R17) second timer capture route c: pin 41 to A, pin 40 to B
// (R18) pins 31, 42, 41, 40 always feed external interrupts a to d
// (R19) pin 29 and 31 feed timer external clocks and enable masks
// (R20) debug port has fixed clock, data in, data out, open-drain strobe
// (R21) one output source per pin, general output when no alternate enabled
package pin_mux_pkg;

	// pad slots, one per shared pin handled here
	localparam int NUM_PADS = 11;
	localparam int PAD_26   = 0;
	localparam int PAD_27   = 1;
	localparam int PAD_29   = 2;
	localparam int PAD_30   = 3;
	localparam int PAD_31   = 4;
	localparam int PAD_32   = 5;
	localparam int PAD_33   = 6;
	localparam int PAD_40   = 7;
	localparam int PAD_41   = 8;
	localparam int PAD_42   = 9;
	localparam int PAD_43   = 10;

	// pin configuration word layout
	localparam int CFG_WIDTH      = 16;
	localparam int CFG_T2_WAVE_A  = 0;
	localparam int CFG_T2_WAVE_B  = 1;
	localparam int CFG_T1_WAVE_A  = 2;
	localparam int CFG_T1_WAVE_B  = 3;
	localparam int CFG_ROUTE_LSB  = 4;
	localparam int CFG_ROUTE_MSB  = 7;
	localparam int CFG_ANALOG_1   = 9;
	localparam int CFG_ANALOG_2   = 10;
	localparam int CFG_ANALOG_3   = 11;
	localparam int CFG_TRACE      = 12;
	localparam int CFG_PIN30_HOLD = 13;
	localparam int CFG_VREF       = 14;
	localparam int SPI_CFG_MASTER = 4;
	localparam int SPI_CFG_WIDTH  = 8;

	// routing field codes for pins 32/33 and capture choices
	localparam logic [3:0] ROUTE_GPIO                        = 4'h0;
	localparam logic [3:0] SERIAL1_UART_FOUR_WIRE_ROUTE      = 4'h1;
	localparam logic [3:0] SERIAL1_TWO_WIRE_ROUTE            = 4'h2;
	localparam logic [3:0] SERIAL1_SPI_MASTER_ROUTE          = 4'h3;
	localparam logic [3:0] TIMER_ONE_CAPTURE_ROUTE_B         = 4'h4;
	localparam logic [3:0] TIMER_ONE_CAPTURE_ROUTE_B_HALF    = 4'h5;
	localparam logic [3:0] TIMER_ONE_CAPTURE_ROUTE_C         = 4'h6;
	localparam logic [3:0] TIMER_ONE_CAPTURE_ROUTE_C_HALF    = 4'h7;
	localparam logic [3:0] TIMER_TWO_CAPTURE_ROUTE_C         = 4'h8;

	// serial controller one mode
	typedef enum logic [1:0] {
		SERIAL1_OFF  = 2'h0,
		SERIAL1_UART = 2'h1,
		SERIAL1_SPI  = 2'h3,
		SERIAL1_I2C  = 2'h2
	} serial1_mode_type;

	// idle levels handed to cores when a pin is not routed to them, plus the released pad enable level
	localparam logic UART_IDLE    = 1'h1;
	localparam logic BUS_IDLE     = 1'h1;
	localparam logic INPUT_QUIET  = 1'h0;
	localparam logic PAD_RELEASED = 1'h1;

	typedef struct packed {
		logic one_a;
		logic one_b;
		logic two_a;
		logic two_b;
	} timer_wave_type;

	typedef struct packed {
		logic one_a;
		logic one_b;
		logic two_a;
		logic two_b;
	} capture_type;

	typedef struct packed {
		logic one_clock;
		logic two_clock;
		logic one_mask;
		logic two_mask;
	} timer_ext_type;

	typedef struct packed {
		logic txd;
		logic master_out;
		logic data_drive_low;
		logic clock_drive_low;
	} serial1_out_type;

	typedef struct packed {
		logic rxd;
		logic master_in;
		logic data_in;
		logic clock_in;
	} serial1_in_type;

	typedef struct packed {
		logic analog_1;
		logic analog_2;
		logic analog_3;
		logic vref_out;
	} analog_sel_type;

	typedef struct packed {
		logic out;
		logic oe_b;
	} pad_state_type;

endpackage

// >>> rtl/pad_out_cell.sv
`timescale 1ns/10ps
// one pad's output stage: alternate source wins, else general output
module pad_out_cell (
	input  wire logic ref_clk,
	input  wire logic rst_b,
	input  wire logic gpio_out,
	input  wire logic gpio_drive,
	input  wire logic alt_en,
	input  wire logic alt_out,
	input  wire logic alt_drive,
	output logic      pad_out,
	output logic      pad_oe_b
);

	pin_mux_pkg::pad_state_type state_q;
	pin_mux_pkg::pad_state_type state_d;

	// single selector, so two sources can never fight on the pad
	always_comb begin
		state_d = state_q;
		if (alt_en) begin
			state_d.out  = alt_out;   // see R21
			state_d.oe_b = ~alt_drive;
		end else begin
			state_d.out  = gpio_out;  // see R21
			state_d.oe_b = ~gpio_drive;
		end
	end

	// released pad after reset keeps the board quiet
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state_q.out  <= 1'h0;
			state_q.oe_b <= pin_mux_pkg::PAD_RELEASED;
		end else begin
			state_q <= state_d;
		end
	end

	assign pad_out  = state_q.out;
	assign pad_oe_b = state_q.oe_b;

endmodule

// >>> rtl/shared_pin_function_mux.sv
`timescale 1ns/10ps
// routes general i/o and alternate functions onto the shared pins
module shared_pin_function_mux #(
	parameter int NUM_PADS = pin_mux_pkg::NUM_PADS
) (
	input  wire logic                                   ref_clk,
	input  wire logic                                   rst_b,
	input  wire logic [pin_mux_pkg::CFG_WIDTH-1:0]      pin_config,
	input  wire pin_mux_pkg::serial1_mode_type          serial1_mode_select,
	input  wire logic [pin_mux_pkg::SPI_CFG_WIDTH-1:0]  serial1_spi_config,
	input  wire logic [NUM_PADS-1:0]                    gpio_out,
	input  wire logic [NUM_PADS-1:0]                    gpio_drive,
	output logic [NUM_PADS-1:0]                         gpio_in,
	input  wire pin_mux_pkg::timer_wave_type            timer_wave,
	input  wire logic                                   trace_frame_out,
	input  wire logic                                   trace_data_out,
	input  wire pin_mux_pkg::serial1_out_type           serial1_core_out,
	output pin_mux_pkg::serial1_in_type                 serial1_core_in,
	output pin_mux_pkg::capture_type                    timer_capture,
	output pin_mux_pkg::timer_ext_type                  timer_ext,
	output logic [3:0]                                  ext_interrupt,
	output pin_mux_pkg::analog_sel_type                 analog_select,
	input  wire logic [NUM_PADS-1:0]                    pad_in,
	output logic [NUM_PADS-1:0]                         pad_out,
	output logic [NUM_PADS-1:0]                         pad_oe_b,
	input  wire logic                                   debug_port_clock,
	input  wire logic                                   debug_port_data_in,
	output logic                                        debug_port_data_out,
	input  wire logic                                   debug_port_load_strobe_in,
	output logic                                        debug_port_load_strobe_out,
	output logic                                        debug_port_load_strobe_oe_b,
	output logic                                        debug_core_clock,
	output logic                                        debug_core_data_in,
	input  wire logic                                   debug_core_data_out,
	input  wire logic                                   debug_core_load_drive_low,
	output logic                                        debug_core_load_seen
);

	// the pin map is fixed; other pad counts have no wiring
	if (NUM_PADS != pin_mux_pkg::NUM_PADS) begin : g_bad_pads
		$error("pad count must match the fixed pin map");
	end

	typedef struct packed {
		logic [NUM_PADS-1:0]         gpio_in;
		pin_mux_pkg::serial1_in_type serial1_in;
		pin_mux_pkg::capture_type    capture;
		pin_mux_pkg::timer_ext_type  ext;
		logic [3:0]                  irq;
		pin_mux_pkg::analog_sel_type analog;
		logic                        dbg_clock;
		logic                        dbg_data_in;
		logic                        dbg_data_out;
		logic                        dbg_load_out;
		logic                        dbg_load_oe_b;
		logic                        dbg_load_seen;
	} mux_state_type;

	mux_state_type       state_q;
	mux_state_type       state_d;
	logic [NUM_PADS-1:0] alt_en;
	logic [NUM_PADS-1:0] alt_out;
	logic [NUM_PADS-1:0] alt_drive;
	logic [3:0]          route;
	logic                uart_on;
	logic                spi_on;
	logic                i2c_on;
	logic                cap1_b;
	logic                cap1_b_full;
	logic                cap1_c;
	logic                cap1_c_full;
	logic                cap2_c;

	// routing field and serial mode decode
	always_comb begin
		route       = pin_config[pin_mux_pkg::CFG_ROUTE_MSB:pin_mux_pkg::CFG_ROUTE_LSB];
		uart_on     = ((route == pin_mux_pkg::SERIAL1_UART_FOUR_WIRE_ROUTE)
		            || (route == pin_mux_pkg::SERIAL1_TWO_WIRE_ROUTE))
		            && (serial1_mode_select == pin_mux_pkg::SERIAL1_UART);     // see R11
		spi_on      = (route == pin_mux_pkg::SERIAL1_SPI_MASTER_ROUTE)
		            && (serial1_mode_select == pin_mux_pkg::SERIAL1_SPI)
		            && serial1_spi_config[pin_mux_pkg::SPI_CFG_MASTER];        // see R13
		i2c_on      = (route == pin_mux_pkg::SERIAL1_TWO_WIRE_ROUTE)
		            && (serial1_mode_select == pin_mux_pkg::SERIAL1_I2C);      // see R14
		cap1_b_full = (route == pin_mux_pkg::TIMER_ONE_CAPTURE_ROUTE_B);
		cap1_b      = cap1_b_full || (route == pin_mux_pkg::TIMER_ONE_CAPTURE_ROUTE_B_HALF);
		cap1_c_full = (route == pin_mux_pkg::TIMER_ONE_CAPTURE_ROUTE_C);
		cap1_c      = cap1_c_full || (route == pin_mux_pkg::TIMER_ONE_CAPTURE_ROUTE_C_HALF);
		cap2_c      = (route == pin_mux_pkg::TIMER_TWO_CAPTURE_ROUTE_C);
	end

	// alternate output sources per pad; analog use takes the pad and releases it
	always_comb begin
		alt_en    = '0;
		alt_out   = '0;
		alt_drive = '0;
		// trace pair owns pins 26 and 27
		alt_en[pin_mux_pkg::PAD_26]    = pin_config[pin_mux_pkg::CFG_TRACE];  // see R5
		alt_out[pin_mux_pkg::PAD_26]   = trace_frame_out;
		alt_drive[pin_mux_pkg::PAD_26] = 1'h1;
		alt_en[pin_mux_pkg::PAD_27]    = pin_config[pin_mux_pkg::CFG_TRACE]
		                               || pin_config[pin_mux_pkg::CFG_ANALOG_1];  // see R6
		alt_out[pin_mux_pkg::PAD_27]   = trace_data_out;                       // see R5
		alt_drive[pin_mux_pkg::PAD_27] = pin_config[pin_mux_pkg::CFG_TRACE];
		// analog pins: digital driver held off
		alt_en[pin_mux_pkg::PAD_29]    = pin_config[pin_mux_pkg::CFG_ANALOG_2];  // see R7
		alt_en[pin_mux_pkg::PAD_30]    = pin_config[pin_mux_pkg::CFG_ANALOG_3]
		                               && !pin_config[pin_mux_pkg::CFG_PIN30_HOLD];  // see R8
		alt_en[pin_mux_pkg::PAD_31]    = pin_config[pin_mux_pkg::CFG_VREF];  // see R9
		// serial controller one on pins 32 and 33; otherwise general i/o
		if (uart_on) begin
			alt_en[pin_mux_pkg::PAD_32]    = 1'h1;  // see R11
			alt_out[pin_mux_pkg::PAD_32]   = serial1_core_out.txd;
			alt_drive[pin_mux_pkg::PAD_32] = 1'h1;
			alt_en[pin_mux_pkg::PAD_33]    = 1'h1;  // see R12
		end else if (spi_on) begin
			alt_en[pin_mux_pkg::PAD_32]    = 1'h1;  // see R13
			alt_out[pin_mux_pkg::PAD_32]   = serial1_core_out.master_out;
			alt_drive[pin_mux_pkg::PAD_32] = 1'h1;
			alt_en[pin_mux_pkg::PAD_33]    = 1'h1;
		end else if (i2c_on) begin
			// open drain: only ever pull low
			alt_en[pin_mux_pkg::PAD_32]    = 1'h1;  // see R14
			alt_drive[pin_mux_pkg::PAD_32] = serial1_core_out.data_drive_low;
			alt_en[pin_mux_pkg::PAD_33]    = 1'h1;
			alt_drive[pin_mux_pkg::PAD_33] = serial1_core_out.clock_drive_low;
		end
		// timer waveforms on pins 40..43
		alt_en[pin_mux_pkg::PAD_43]    = pin_config[pin_mux_pkg::CFG_T2_WAVE_A];  // see R1
		alt_out[pin_mux_pkg::PAD_43]   = timer_wave.two_a;
		alt_drive[pin_mux_pkg::PAD_43] = 1'h1;
		alt_en[pin_mux_pkg::PAD_42]    = pin_config[pin_mux_pkg::CFG_T2_WAVE_B];  // see R2
		alt_out[pin_mux_pkg::PAD_42]   = timer_wave.two_b;
		alt_drive[pin_mux_pkg::PAD_42] = 1'h1;
		alt_en[pin_mux_pkg::PAD_41]    = pin_config[pin_mux_pkg::CFG_T1_WAVE_A];  // see R3
		alt_out[pin_mux_pkg::PAD_41]   = timer_wave.one_a;
		alt_drive[pin_mux_pkg::PAD_41] = 1'h1;
		alt_en[pin_mux_pkg::PAD_40]    = pin_config[pin_mux_pkg::CFG_T1_WAVE_B];  // see R4
		alt_out[pin_mux_pkg::PAD_40]   = timer_wave.one_b;
		alt_drive[pin_mux_pkg::PAD_40] = 1'h1;
	end

	// inputs handed to cores; unrouted inputs rest at their idle level
	always_comb begin
		state_d         = state_q;
		state_d.gpio_in = pad_in;  // see R10
		state_d.serial1_in.rxd       = uart_on ? pad_in[pin_mux_pkg::PAD_33] : pin_mux_pkg::UART_IDLE;  // see R12
		state_d.serial1_in.master_in = spi_on ? pad_in[pin_mux_pkg::PAD_33] : pin_mux_pkg::INPUT_QUIET;  // see R13
		state_d.serial1_in.data_in   = i2c_on ? pad_in[pin_mux_pkg::PAD_32] : pin_mux_pkg::BUS_IDLE;  // see R14
		state_d.serial1_in.clock_in  = i2c_on ? pad_in[pin_mux_pkg::PAD_33] : pin_mux_pkg::BUS_IDLE;
		// capture inputs
		state_d.capture.one_a = pin_mux_pkg::INPUT_QUIET;
		state_d.capture.one_b = pin_mux_pkg::INPUT_QUIET;
		if (cap1_b) begin
			state_d.capture.one_a = pad_in[pin_mux_pkg::PAD_32];  // see R15
			state_d.capture.one_b = cap1_b_full ? pad_in[pin_mux_pkg::PAD_33] : pin_mux_pkg::INPUT_QUIET;
		end else if (cap1_c) begin
			state_d.capture.one_a = pad_in[pin_mux_pkg::PAD_43];  // see R16
			state_d.capture.one_b = cap1_c_full ? pad_in[pin_mux_pkg::PAD_42] : pin_mux_pkg::INPUT_QUIET;
		end
		state_d.capture.two_a = cap2_c ? pad_in[pin_mux_pkg::PAD_41] : pin_mux_pkg::INPUT_QUIET;  // see R17
		state_d.capture.two_b = cap2_c ? pad_in[pin_mux_pkg::PAD_40] : pin_mux_pkg::INPUT_QUIET;
		// timer clocks, masks and interrupts follow their pins always
		state_d.ext.two_clock = pad_in[pin_mux_pkg::PAD_29];  // see R19
		state_d.ext.one_mask  = pad_in[pin_mux_pkg::PAD_29];
		state_d.ext.one_clock = pad_in[pin_mux_pkg::PAD_31];
		state_d.ext.two_mask  = pad_in[pin_mux_pkg::PAD_31];
		state_d.irq           = {pad_in[pin_mux_pkg::PAD_40], pad_in[pin_mux_pkg::PAD_41],
		                         pad_in[pin_mux_pkg::PAD_42], pad_in[pin_mux_pkg::PAD_31]};  // see R18
		// analog selects; trace use on pin 27 beats analog input 1
		state_d.analog.analog_1 = pin_config[pin_mux_pkg::CFG_ANALOG_1]
		                        && !pin_config[pin_mux_pkg::CFG_TRACE];  // see R6
		state_d.analog.analog_2 = pin_config[pin_mux_pkg::CFG_ANALOG_2];  // see R7
		state_d.analog.analog_3 = pin_config[pin_mux_pkg::CFG_ANALOG_3]
		                        && !pin_config[pin_mux_pkg::CFG_PIN30_HOLD];  // see R8
		state_d.analog.vref_out = pin_config[pin_mux_pkg::CFG_VREF];  // see R9
		// dedicated debug port, never shared
		state_d.dbg_clock     = debug_port_clock;  // see R20
		state_d.dbg_data_in   = debug_port_data_in;
		state_d.dbg_data_out  = debug_core_data_out;
		state_d.dbg_load_out  = 1'h0;
		state_d.dbg_load_oe_b = ~debug_core_load_drive_low;  // see R20
		state_d.dbg_load_seen = ~debug_port_load_strobe_in;
	end

	// one register stage keeps core-side inputs glitch free
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state_q                    <= '0;
			state_q.serial1_in.rxd     <= pin_mux_pkg::UART_IDLE;
			state_q.serial1_in.data_in <= pin_mux_pkg::BUS_IDLE;
			state_q.serial1_in.clock_in <= pin_mux_pkg::BUS_IDLE;
			state_q.dbg_load_oe_b      <= pin_mux_pkg::PAD_RELEASED;
		end else begin
			state_q <= state_d;
		end
	end

	// per-pad output stage
	for (genvar i = 0; i < NUM_PADS; i++) begin : g_pad
		pad_out_cell u_cell (
			.ref_clk   (ref_clk),
			.rst_b     (rst_b),
			.gpio_out  (gpio_out[i]),
			.gpio_drive(gpio_drive[i]),
			.alt_en    (alt_en[i]),
			.alt_out   (alt_out[i]),
			.alt_drive (alt_drive[i]),
			.pad_out   (pad_out[i]),
			.pad_oe_b  (pad_oe_b[i])
		);
	end

	// outputs straight from flops
	assign gpio_in                     = state_q.gpio_in;
	assign serial1_core_in             = state_q.serial1_in;
	assign timer_capture               = state_q.capture;
	assign timer_ext                   = state_q.ext;
	assign ext_interrupt               = state_q.irq;
	assign analog_select               = state_q.analog;
	assign debug_core_clock            = state_q.dbg_clock;
	assign debug_core_data_in          = state_q.dbg_data_in;
	assign debug_port_data_out         = state_q.dbg_data_out;
	assign debug_port_load_strobe_out  = state_q.dbg_load_out;
	assign debug_port_load_strobe_oe_b = state_q.dbg_load_oe_b;
	assign debug_core_load_seen        = state_q.dbg_load_seen;

	// checks on routing, each one cycle after the cause
	AST_T2_WAVE_A: assert property (@(posedge ref_clk) disable iff (!rst_b) // see R1
		pin_config[pin_mux_pkg::CFG_T2_WAVE_A] |=> (pad_out[pin_mux_pkg::PAD_43] == $past(timer_wave.two_a))
		&& !pad_oe_b[pin_mux_pkg::PAD_43]) else $error("pin 43 not carrying timer two wave a");
	AST_T2_WAVE_B: assert property (@(posedge ref_clk) disable iff (!rst_b) // see R2
		pin_config[pin_mux_pkg::CFG_T2_WAVE_B] |=> (pad_out[pin_mux_pkg::PAD_42] == $past(timer_wave.two_b))
		&& !pad_oe_b[pin_mux_pkg::PAD_42]) else $error("pin 42 not carrying timer two wave b");
	AST_T1_WAVE_A: assert property (@(posedge ref_clk) disable iff (!rst_b) // see R3
		pin_config[pin_mux_pkg::CFG_T1_WAVE_A] |=> (pad_out[pin_mux_pkg::PAD_41] == $past(timer_wave.one_a))
		&& !pad_oe_b[pin_mux_pkg::PAD_41]) else $error("pin 41 not carrying timer one wave a");
	AST_T1_WAVE_B: assert property (@(posedge ref_clk) disable iff (!rst_b) // see R4
		pin_config[pin_mux_pkg::CFG_T1_WAVE_B] |=> (pad_out[pin_mux_pkg::PAD_40] == $past(timer_wave.one_b))
		&& !pad_oe_b[pin_mux_pkg::PAD_40]) else $error("pin 40 not carrying timer one wave b");
	AST_TRACE: assert property (@(posedge ref_clk) disable iff (!rst_b) // see R5
		pin_config[pin_mux_pkg::CFG_TRACE] |=> (pad_out[pin_mux_pkg::PAD_26] == $past(trace_frame_out))
		&& (pad_out[pin_mux_pkg::PAD_27] == $past(trace_data_out)) && !analog_select.analog_1)
		else $error("trace pins not driven");
	AST_GPIO_PASS: assert property (@(posedge ref_clk) disable iff (!rst_b) // see R10
		(route == pin_mux_pkg::ROUTE_GPIO) |=> (pad_out[pin_mux_pkg::PAD_32] == $past(gpio_out[pin_mux_pkg::PAD_32]))
		&& (pad_oe_b[pin_mux_pkg::PAD_33] == !$past(gpio_drive[pin_mux_pkg::PAD_33])))
		else $error("pins 32/33 not general i/o");
	AST_UART_TX: assert property (@(posedge ref_clk) disable iff (!rst_b) // see R11
		uart_on |=> (pad_out[pin_mux_pkg::PAD_32] == $past(serial1_core_out.txd))
		&& (serial1_core_in.rxd == $past(pad_in[pin_mux_pkg::PAD_33]))) else $error("uart routing wrong");
	AST_I2C_OPEN_DRAIN: assert property (@(posedge ref_clk) disable iff (!rst_b) // see R14
		i2c_on |=> !pad_out[pin_mux_pkg::PAD_32] && !pad_out[pin_mux_pkg::PAD_33]
		&& (pad_oe_b[pin_mux_pkg::PAD_33] == !$past(serial1_core_out.clock_drive_low)))
		else $error("two-wire pins drive high");
	AST_CAPTURE_B: assert property (@(posedge ref_clk) disable iff (!rst_b) // see R15
		cap1_b_full |=> (timer_capture.one_a == $past(pad_in[pin_mux_pkg::PAD_32]))
		&& (timer_capture.one_b == $past(pad_in[pin_mux_pkg::PAD_33]))) else $error("capture route b wrong");
	AST_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_b) // see R18
		1'h1 |=> (ext_interrupt[0] == $past(pad_in[pin_mux_pkg::PAD_31]))
		&& (ext_interrupt[3] == $past(pad_in[pin_mux_pkg::PAD_40]))) else $error("interrupt pin map wrong");
	AST_ONE_SOURCE: assert property (@(posedge ref_clk) disable iff (!rst_b) // see R21
		(alt_en == '0) |=> (pad_out == $past(gpio_out)) && (pad_oe_b == ~$past(gpio_drive)))
		else $error("general output not on idle pins");
	AST_ANALOG_2: assert property (@(posedge ref_clk) disable iff (!rst_b) // see R7
		pin_config[pin_mux_pkg::CFG_ANALOG_2] |=> analog_select.analog_2 && pad_oe_b[pin_mux_pkg::PAD_29])
		else $error("pin 29 not released for analog input");
	AST_SPI_MASTER: assert property (@(posedge ref_clk) disable iff (!rst_b) // see R13
		spi_on |=> (pad_out[pin_mux_pkg::PAD_32] == $past(serial1_core_out.master_out)) && !pad_oe_b[pin_mux_pkg::PAD_32]
		&& (serial1_core_in.master_in == $past(pad_in[pin_mux_pkg::PAD_33]))) else $error("spi master routing wrong");
	AST_CAPTURE_T2: assert property (@(posedge ref_clk) disable iff (!rst_b) // see R17
		cap2_c |=> (timer_capture.two_a == $past(pad_in[pin_mux_pkg::PAD_41]))
		&& (timer_capture.two_b == $past(pad_in[pin_mux_pkg::PAD_40]))) else $error("timer two capture route wrong");
	AST_DEBUG_STROBE: assert property (@(posedge ref_clk) disable iff (!rst_b) // see R20
		1'h1 |=> !debug_port_load_strobe_out
		&& (debug_port_load_strobe_oe_b == !$past(debug_core_load_drive_low))) else $error("debug strobe not open drain");

	COV_UART: cover property (@(posedge ref_clk) disable iff (!rst_b) uart_on ##1 uart_on);
	COV_I2C_LOW: cover property (@(posedge ref_clk) disable iff (!rst_b)
		i2c_on && serial1_core_out.data_drive_low);
	COV_CAP_C: cover property (@(posedge ref_clk) disable iff (!rst_b) cap1_c_full && cap2_c == 1'h0);
	COV_TRACE: cover property (@(posedge ref_clk) disable iff (!rst_b) pin_config[pin_mux_pkg::CFG_TRACE]);

endmodule

// >>> tb/pin_partner.sv
`timescale 1ns/10ps
// far side of the shared pins and of the debug strobe
module pin_partner (
	input  wire logic [10:0] pad_out,
	input  wire logic [10:0] pad_oe_b,
	input  wire logic [10:0] far_level,
	input  wire logic        strobe_out,
	input  wire logic        strobe_oe_b,
	input  wire logic        host_strobe,
	output logic [10:0]      pad_in,
	output logic             strobe_in
);
	// a released wire shows a fresh random level each cycle, never a stale copy
	always_comb begin
		pad_in    = (pad_oe_b & far_level) | (~pad_oe_b & pad_out);
		strobe_in = host_strobe & (strobe_oe_b | strobe_out);
	end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	typedef struct packed {
		logic [10:0] pout;
		logic [10:0] poe;
		logic [10:0] gin;
		logic [3:0]  sin;
		logic [3:0]  cap;
		logic [3:0]  tex;
		logic [3:0]  irq;
		logic [3:0]  an;
		logic [5:0]  dbg;
	} exp_type;
	logic                            ref_clk;
	logic                            rst_b = 1'h0;
	logic [15:0]                     cfg   = '0;
	pin_mux_pkg::serial1_mode_type   mode  = pin_mux_pkg::SERIAL1_OFF;
	logic [7:0]                      spi   = '0;
	logic [10:0]                     gout  = '0;
	logic [10:0]                     gdrv  = '0;
	logic [10:0]                     far   = '0;
	pin_mux_pkg::timer_wave_type     wave  = '0;
	pin_mux_pkg::serial1_out_type    cout  = '0;
	logic [1:0]                      tr    = '0;
	logic [4:0]                      dbi   = '0;
	logic [10:0]                     gin;
	logic [10:0]                     pin;
	logic [10:0]                     pout;
	logic [10:0]                     poe;
	pin_mux_pkg::serial1_in_type     sin;
	pin_mux_pkg::capture_type        cap;
	pin_mux_pkg::timer_ext_type      tex;
	pin_mux_pkg::analog_sel_type     an;
	logic [3:0]                      irq;
	logic [5:0]                      dbo;
	logic                            stb;
	exp_type                         notes[$];
	exp_type                         prev;
	exp_type                         got;
	integer                          seed = 33;
	int                              num_errors = 0;
	int                              samples_checked = 0;

	shared_pin_function_mux u_shared_pin_function_mux (.ref_clk(ref_clk), .rst_b(rst_b), .pin_config(cfg),
		.serial1_mode_select(mode), .serial1_spi_config(spi), .gpio_out(gout), .gpio_drive(gdrv), .gpio_in(gin),
		.timer_wave(wave), .trace_frame_out(tr[0]), .trace_data_out(tr[1]), .serial1_core_out(cout),
		.serial1_core_in(sin), .timer_capture(cap), .timer_ext(tex), .ext_interrupt(irq), .analog_select(an),
		.pad_in(pin), .pad_out(pout), .pad_oe_b(poe), .debug_port_clock(dbi[3]), .debug_port_data_in(dbi[2]),
		.debug_port_data_out(dbo[5]), .debug_port_load_strobe_in(stb), .debug_port_load_strobe_out(dbo[4]),
		.debug_port_load_strobe_oe_b(dbo[3]), .debug_core_clock(dbo[2]), .debug_core_data_in(dbo[1]),
		.debug_core_data_out(dbi[1]), .debug_core_load_drive_low(dbi[0]), .debug_core_load_seen(dbo[0]));
	pin_partner u_pin_partner (.pad_out(pout), .pad_oe_b(poe), .far_level(far), .strobe_out(dbo[4]),
		.strobe_oe_b(dbo[3]), .host_strobe(dbi[4]), .pad_in(pin), .strobe_in(stb));

	initial begin
		ref_clk = 1'h0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// random step: drive inputs, note the outputs due one edge later
	task automatic drive_step();
		logic [63:0]                  r;
		logic [15:0]                  c;
		logic [10:0]                  fl;
		logic [10:0]                  pn;
		logic [3:0]                   rt;
		logic                         ua;
		logic                         sp;
		logic                         ic;
		pin_mux_pkg::timer_wave_type  w;
		pin_mux_pkg::serial1_out_type co;
		exp_type                      e;
		r = {$random(seed), $random(seed)};
		fl = 11'($random(seed));
		rt = 4'({$random(seed)} % 10);  // code 9 is unmapped
		c = {r[15:8], rt, r[3:0]};
		w = r[51:48];
		co = r[57:54];
		cfg <= c;
		mode <= pin_mux_pkg::serial1_mode_type'(r[17:16]);
		spi <= r[25:18];
		gout <= r[36:26];
		gdrv <= r[47:37];
		wave <= w;
		tr <= r[53:52];
		cout <= co;
		far <= fl;
		dbi <= r[62:58];
		ua = (rt == 4'h1 || rt == 4'h2) && r[17:16] == 2'h1;
		sp = rt == 4'h3 && r[17:16] == 2'h3 && r[22];
		ic = rt == 4'h2 && r[17:16] == 2'h2;
		// wire levels seen at the sampling edge: last driven pads, else the far side
		pn = (prev.poe & fl) | (~prev.poe & prev.pout);
		e.poe = ~r[47:37];
		e.pout = r[36:26];
		if (c[0]) {e.pout[10], e.poe[10]} = {w.two_a, 1'h0};
		if (c[1]) {e.pout[9], e.poe[9]} = {w.two_b, 1'h0};
		if (c[2]) {e.pout[8], e.poe[8]} = {w.one_a, 1'h0};
		if (c[3]) {e.pout[7], e.poe[7]} = {w.one_b, 1'h0};
		if (c[12]) {e.pout[1:0], e.poe[1:0]} = {r[53:52], 2'h0};
		else if (c[9]) e.poe[1] = 1'h1;
		if (c[10]) e.poe[2] = 1'h1;
		if (c[11] & ~c[13]) e.poe[3] = 1'h1;
		if (c[14]) e.poe[4] = 1'h1;
		if (ua | sp) {e.pout[5], e.poe[6:5]} = {ua ? co.txd : co.master_out, 2'h2};
		if (ic) {e.pout[6:5], e.poe[6:5]} = {2'h0, ~co.clock_drive_low, ~co.data_drive_low};
		e.pout = e.pout & ~e.poe;
		e.gin = pn;
		e.sin = {ua ? pn[6] : 1'h1, sp ? pn[6] : 1'h0, ic ? pn[5] : 1'h1, ic ? pn[6] : 1'h1};
		e.cap[3] = (rt == 4'h4 || rt == 4'h5) ? pn[5] : (rt == 4'h6 || rt == 4'h7) ? pn[10] : 1'h0;
		e.cap[2:0] = {rt == 4'h4 ? pn[6] : rt == 4'h6 ? pn[9] : 1'h0, rt == 4'h8 ? pn[8:7] : 2'h0};
		e.tex = {pn[4], pn[2], pn[2], pn[4]};
		e.irq = {pn[7], pn[8], pn[9], pn[4]};
		e.an = {~c[12] & c[9], c[10], c[11] & ~c[13], c[14]};
		e.dbg = {r[59], 1'h0, ~r[58], r[61], r[60], ~(r[62] & prev.dbg[3])};
		notes.push_back(e);
		prev = e;
	endtask

	// each result is compared with the oldest note once the next note exists
	always @(negedge ref_clk) begin
		if (notes.size() > 1) begin
			got = notes.pop_front();
			check("pad enable", 32'(poe), 32'(got.poe));
			check("pad level", 32'(pout & ~poe), 32'(got.pout));
			check("gpio in", 32'(gin), 32'(got.gin));
			check("core in", 32'(sin), 32'(got.sin));
			check("capture", 32'({cap, tex, irq}), 32'({got.cap, got.tex, got.irq}));
			check("analog", 32'(an), 32'(got.an));
			check("debug", 32'(dbo), 32'(got.dbg));
		end
	end

	initial begin
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		check("reset pads", 32'({poe, sin}), 32'({11'h7ff, 4'hb}));
		@(posedge ref_clk);
		rst_b <= 1'h1;
		prev = '0;
		prev.poe = '1;
		prev.dbg[3] = 1'h1;
		repeat (3000) begin
			drive_step();
			@(posedge ref_clk);
		end
		@(negedge ref_clk);
		wrap_up();
	end

	// hang guard, well past the 3005 cycles the run needs
	initial begin
		#400000;
		num_errors++;
		wrap_up();
	end
endmodule
